// [src/eic_pkg.sv]
/*
 Shared constants and types for the external interrupt controller.
 Assumes a 50 MHz core clock and a CPU that acknowledges service.
*/
// Contract
// - Four priority levels, thirteen sources
// - Per-source enable bit gates each source
// - Global enable clear blocks all sources; irq_o ignores it and follows stat & mask
// - Two active-low external request pins
// - Trigger bit 0: low level requests
// - Trigger bit 1: high then low sets
// - Pins sampled once per machine cycle
// - Edge flag cleared on service entry
// - Level still low re-requests after return
// - Level flag follows sampled pin
// - Enabled external request wakes processor
package eic_pkg;
	localparam int NUM_SRC = 13;
	localparam int NUM_LVL = 4;
	localparam int SRC_W = 4;
	localparam int CLK_PER_MC = 6;
	localparam logic [2:0] SAMPLE_PHASE = 3'h5;
	localparam logic [2:0] MC_LAST = 3'h5;
	localparam logic [3:0] ADDR_EN_A = 4'h0;
	localparam logic [3:0] ADDR_EN_B = 4'h1;
	localparam logic [3:0] ADDR_CTRL = 4'h2;
	localparam logic [3:0] ADDR_PRIO_LO = 4'h3;
	localparam logic [3:0] ADDR_PRIO_HI = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h5;
	localparam logic [3:0] ADDR_MASK = 4'h6;
	localparam logic [3:0] ADDR_ACT = 4'h7;
	localparam int GIE_BIT = 7;
	localparam int TRIG0_BIT = 0;
	localparam int TRIG1_BIT = 1;
	localparam logic [7:0] EN_RST = 8'h00;
	localparam logic [12:0] PRIO_RST = 13'h0000;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} eic_bus_type;
	typedef struct packed {
		logic valid;
		logic [1:0] level;
		logic [3:0] source;
	} eic_req_type;
	typedef enum logic [1:0] {
		EIC_RUN = 2'b00,
		EIC_SLEEP = 2'b01
	} eic_pwr_type;
endpackage

// [src/eic_top.sv]
/*
 External interrupt controller: two external pins, thirteen sources,
 four-level arbitration, wake from idle or power down.
 Assumes the CPU pulses ack with the granted source on service entry
 and pulses ret when the service routine returns.
*/
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module eic_top
	import eic_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [1:0] ext_irq_pin_n_i,
	input wire logic [10:0] int_src_i,
	input wire logic ack_i,
	input wire logic [3:0] ack_src_i,
	input wire logic ret_i,
	input wire logic sleep_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	output logic req_valid_o,
	output logic [3:0] req_src_o,
	output logic [1:0] req_level_o,
	output logic wake_o,
	output logic irq_o
);
	eic_bus_type bus;
	eic_req_type next_req;
	eic_pwr_type pwr;
	logic [7:0] interrupt_enable_reg_a;
	logic [7:0] interrupt_enable_reg_b;
	logic [1:0] ext_trigger_type_bit;
	logic [12:0] prio_lo;
	logic [12:0] prio_hi;
	logic [1:0] pin_meta;
	logic [1:0] pin_sync;
	logic [1:0] pin_smp;
	logic [1:0] ext_irq_request_flag;
	logic [2:0] mc_cnt;
	logic sample_now;
	logic [12:0] pending;
	logic [12:0] enabled;
	logic [1:0] stat;
	logic [1:0] mask;
	logic [1:0] active_lvl;
	logic in_service;
	logic [1:0] ev;

	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	// Thirteen-bit enable view: bits 0..6 of reg a, 0..5 of reg b
	function automatic logic [12:0] en_vec(input logic [7:0] a,
		input logic [7:0] b);
		en_vec = {b[5:0], a[6:0]};
	endfunction

	// Source number each pin raises; pin 1 sits at 2, not 1
	function automatic logic [3:0] ext_src(input int pin);
		ext_src = (pin == 0) ? 4'h0 : 4'h2;
	endfunction

	// Machine cycle counter, sampling at one fixed phase
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mc_cnt <= 3'h0;
		end else if (mc_cnt == MC_LAST) begin
			mc_cnt <= 3'h0;
		end else begin
			mc_cnt <= mc_cnt + 3'h1;
		end
	end
	assign sample_now = (mc_cnt == SAMPLE_PHASE);

	// Pins come from outside; two flops before anything reads them
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_meta <= 2'h3;
			pin_sync <= 2'h3;
		end else begin
			pin_meta <= ext_irq_pin_n_i;
			pin_sync <= pin_meta;
		end
	end

	// One sample per machine cycle; pins held 6 clocks are always seen
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_smp <= 2'h3;
		end else if (sample_now) begin
			pin_smp <= pin_sync;
		end
	end

	// Request flags per external input
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ext
			always_ff @(posedge clk_sys_i or negedge nrst_i) begin
				if (!nrst_i) begin
					ext_irq_request_flag[gi] <= 1'b0;
				end else if (!ext_trigger_type_bit[gi]) begin
					// Level mode mirrors the sample; no clear needed
					ext_irq_request_flag[gi] <= ~pin_smp[gi];
				end else if (sample_now && pin_smp[gi] && !pin_sync[gi]) begin
					// Set wins over a same-cycle acknowledge
					ext_irq_request_flag[gi] <= 1'b1;
				end else if (ack_i && ack_src_i == ext_src(gi)) begin
					ext_irq_request_flag[gi] <= 1'b0;
				end
			end
		end
	endgenerate
	assign ev = {sample_now & pin_smp[1] & ~pin_sync[1],
		sample_now & pin_smp[0] & ~pin_sync[0]};

	// Software-visible registers
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			interrupt_enable_reg_a <= EN_RST;
			interrupt_enable_reg_b <= EN_RST;
			ext_trigger_type_bit <= 2'h0;
			prio_lo <= PRIO_RST;
			prio_hi <= PRIO_RST;
			mask <= 2'h0;
		end else if (bus.wr) begin
			case (bus.addr)
				ADDR_EN_A: interrupt_enable_reg_a <= bus.wdata;
				ADDR_EN_B: interrupt_enable_reg_b <= bus.wdata;
				ADDR_CTRL: ext_trigger_type_bit <= {bus.wdata[TRIG1_BIT],
					bus.wdata[TRIG0_BIT]};
				ADDR_PRIO_LO: prio_lo <= {prio_lo[12:8], bus.wdata};
				ADDR_PRIO_HI: prio_hi <= {prio_hi[12:8], bus.wdata};
				ADDR_MASK: mask <= bus.wdata[1:0];
				default: ;
			endcase
		end
	end

	// Sticky event bits; write one to clear, set wins
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stat <= 2'h0;
		end else begin
			stat <= (stat & ~((bus.wr && bus.addr == ADDR_STAT) ?
				bus.wdata[1:0] : 2'h0)) | ev;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(stat & mask);
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				ADDR_EN_A: rdata_o <= interrupt_enable_reg_a;
				ADDR_EN_B: rdata_o <= interrupt_enable_reg_b;
				ADDR_CTRL: rdata_o <= {4'h0, ext_irq_request_flag,
					ext_trigger_type_bit};
				ADDR_PRIO_LO: rdata_o <= prio_lo[7:0];
				ADDR_PRIO_HI: rdata_o <= prio_hi[7:0];
				ADDR_STAT: rdata_o <= {6'h00, stat};
				ADDR_MASK: rdata_o <= {6'h00, mask};
				ADDR_ACT: rdata_o <= {5'h00, in_service, active_lvl};
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Sources 0 and 2 are the external pins, others come from peers
	assign pending = {int_src_i[10:1], ext_irq_request_flag[1],
		int_src_i[0], ext_irq_request_flag[0]};
	assign enabled = pending & en_vec(interrupt_enable_reg_a,
		interrupt_enable_reg_b) &
		{NUM_SRC{interrupt_enable_reg_a[GIE_BIT]}};

	// Arbiter: only 8 priority bits per byte are writable, so
	// sources 8..12 stay at level 0 in the high bits
	always_comb begin
		next_req = '0;
		for (int l = NUM_LVL - 1; l >= 0; l--) begin
			for (int s = NUM_SRC - 1; s >= 0; s--) begin
				if (enabled[s] && {prio_hi[s], prio_lo[s]} == 2'(l) &&
					!next_req.valid) begin
					next_req.valid = 1'b1;
					next_req.level = 2'(l);
					next_req.source = 4'(s);
				end
			end
		end
		// Lowest index wins within a level
		for (int s = NUM_SRC - 1; s >= 0; s--) begin
			if (enabled[s] && next_req.valid &&
				{prio_hi[s], prio_lo[s]} == next_req.level) begin
				next_req.source = 4'(s);
			end
		end
		if (in_service && next_req.level <= active_lvl) begin
			next_req.valid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_valid_o <= 1'b0;
			req_src_o <= 4'h0;
			req_level_o <= 2'h0;
		end else begin
			req_valid_o <= next_req.valid;
			req_src_o <= next_req.source;
			req_level_o <= next_req.level;
		end
	end

	// Service nesting, single level depth
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			in_service <= 1'b0;
			active_lvl <= 2'h0;
		end else if (ack_i) begin
			in_service <= 1'b1;
			active_lvl <= req_level_o;
		end else if (ret_i) begin
			in_service <= 1'b0;
		end
	end

	// Sleep tracking and wake on an enabled external request
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pwr <= EIC_RUN;
			wake_o <= 1'b0;
		end else begin
			wake_o <= 1'b0;
			case (pwr)
				EIC_RUN: begin
					if (sleep_i) begin
						pwr <= EIC_SLEEP;
					end
				end
				EIC_SLEEP: begin
					if (|{enabled[2], enabled[0]}) begin
						pwr <= EIC_RUN;
						wake_o <= 1'b1;
					end
				end
				default: pwr <= EIC_RUN;
			endcase
		end
	end

	// Elaboration check
	if (NUM_SRC != 13 || CLK_PER_MC != 6) begin : g_bad
		$error("Unsupported source count or cycle length");
	end

	// Checks; pin 1 literals kept apart from ext_src on purpose
	a_mc_wrap: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		mc_cnt == MC_LAST |=> mc_cnt == 3'h0)
		else $error("Machine cycle not six clocks");
	a_mc_range: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		mc_cnt <= MC_LAST)
		else $error("Machine cycle counter out of range");
	a_sample_gap: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		sample_now |=> (!sample_now) [*5] ##1 sample_now)
		else $error("Pin samples not six clocks apart");
	a_gie_block: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		!interrupt_enable_reg_a[GIE_BIT] |=> !req_valid_o)
		else $error("Request with global enable clear");
	a_en_gate: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		next_req.valid |-> enabled[next_req.source])
		else $error("Disabled source granted");
	a_src_range: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		req_valid_o |-> req_src_o < 4'(NUM_SRC))
		else $error("Granted source out of range");
	a_level_track: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		!ext_trigger_type_bit[0] && $stable(ext_trigger_type_bit[0])
		|-> ext_irq_request_flag[0] == ~$past(pin_smp[0]))
		else $error("Level flag not tracking pin");
	a_level_track_b: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		!ext_trigger_type_bit[1] && $stable(ext_trigger_type_bit[1])
		|-> ext_irq_request_flag[1] == ~$past(pin_smp[1]))
		else $error("Pin 1 level flag not tracking pin");
	a_edge_set: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ext_trigger_type_bit[0] && sample_now && pin_smp[0] && !pin_sync[0]
		|=> ext_irq_request_flag[0])
		else $error("Edge not latched");
	a_edge_set_b: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ext_trigger_type_bit[1] && sample_now && pin_smp[1] && !pin_sync[1]
		|=> ext_irq_request_flag[1])
		else $error("Pin 1 edge not latched");
	a_edge_clr: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ext_trigger_type_bit[0] && ack_i && ack_src_i == 4'h0 && !ev[0]
		&& $stable(ext_trigger_type_bit) |=> !ext_irq_request_flag[0])
		else $error("Edge flag not cleared on service");
	a_edge_clr_b: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ext_trigger_type_bit[1] && ack_i && ack_src_i == 4'h2 && !ev[1]
		&& $stable(ext_trigger_type_bit) |=> !ext_irq_request_flag[1])
		else $error("Pin 1 edge flag not cleared on service");
	a_edge_hold: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ext_trigger_type_bit[0] && ext_irq_request_flag[0]
		&& !(ack_i && ack_src_i == 4'h0) |=> ext_irq_request_flag[0])
		else $error("Edge flag lost without service");
	a_sample_hold: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		!sample_now |=> $stable(pin_smp))
		else $error("Pin sampled off phase");
	a_service_block: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		in_service && next_req.valid |-> next_req.level > active_lvl)
		else $error("Request not above active level");
	a_act_hold: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		!ack_i |=> $stable(active_lvl))
		else $error("Active level moved without service");
	a_ret_clear: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ret_i && !ack_i |=> !in_service)
		else $error("Service not ended on return");
	a_wake_pulse: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		pwr == EIC_SLEEP && (enabled[0] || enabled[2]) |=> wake_o)
		else $error("No wake on enabled request");
	a_wake_sleep: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		wake_o |-> $past(pwr) == EIC_SLEEP)
		else $error("Wake outside sleep");
	a_irq_follow: assert property (
		@(posedge clk_sys_i) disable iff (!nrst_i)
		irq_o == $past(|(stat & mask)))
		else $error("Interrupt line not following status");
endmodule
`default_nettype wire

// [dv/eic_pin_model.sv]
/*
 Model of the external devices driving the two request pins.
 Assumes the bench commands the wanted pin levels; pins idle high.
*/
`timescale 1ns/10ps
`default_nettype none
module eic_pin_model (
	input wire logic clk_sys_i,
	input wire logic [1:0] want_n_i,
	output logic [1:0] pin_n_o
);
	logic [3:0] held [2];
	initial pin_n_o = 2'h3;
	initial held = '{4'h0, 4'h0};
	always @(posedge clk_sys_i) begin
		for (int i = 0; i < 2; i++) begin
			// Each level kept 12 clocks, beyond sync and phase
			if (want_n_i[i] != pin_n_o[i] && held[i] >= 4'hB) begin
				pin_n_o[i] <= want_n_i[i];
				held[i] <= 4'h0;
			end else if (held[i] != 4'hF) begin
				held[i] <= held[i] + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [dv/testbench.sv]
/*
 Self-checking bench for the external interrupt controller.
 Assumes the pin model on the request pins; only t_src drives internal sources.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import eic_pkg::*;
	logic clk_sys_i, nrst_i, ack_i, ret_i, sleep_i, wr_i, rd_i;
	logic req_valid_o, wake_o, irq_o;
	logic [1:0] want_n, pin_n, req_level_o;
	logic [10:0] int_src_i;
	logic [3:0] ack_src_i, addr_i, req_src_o;
	logic [7:0] wdata_i, rdata_o;
	int n_mismatch = 0;
	int n_checks = 0;
	eic_pin_model u_pins (.clk_sys_i(clk_sys_i), .want_n_i(want_n),
		.pin_n_o(pin_n));
	eic_top u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.ext_irq_pin_n_i(pin_n), .int_src_i(int_src_i), .ack_i(ack_i),
		.ack_src_i(ack_src_i), .ret_i(ret_i), .sleep_i(sleep_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .req_valid_o(req_valid_o), .req_src_o(req_src_o),
		.req_level_o(req_level_o), .wake_o(wake_o), .irq_o(irq_o));
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string w);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(negedge clk_sys_i);
		chk(w, e, rdata_o);
	endtask
	// One-cycle pulse on ack, ret, sleep
	task automatic pulse(input logic [2:0] w);
		@(posedge clk_sys_i);
		{ack_i, ret_i, sleep_i} <= w;
		@(posedge clk_sys_i);
		{ack_i, ret_i, sleep_i} <= 3'h0;
	endtask
	task automatic pins(input logic [1:0] p);
		@(posedge clk_sys_i);
		want_n <= p;
	endtask
	// Bound covers two sync flops, phase and pin model hold
	task automatic wait_req(input logic e);
		int k;
		for (k = 0; k < 80 && req_valid_o !== e; k++) @(negedge clk_sys_i);
		chk("req_valid", {7'h0, e}, {7'h0, req_valid_o});
		if (k == 80) close_out();
	endtask
	task automatic t_regs;
		rd(ADDR_EN_A, EN_RST, "en_a reset");
		rd(ADDR_PRIO_LO, 8'h00, "prio reset");
		wr(ADDR_EN_A, 8'h85);
		wr(4'hC, 8'hFF);
		rd(4'hC, 8'h00, "unmapped");
		rd(ADDR_EN_A, 8'h85, "en_a");
		$display("test regs done");
	endtask
	task automatic t_level;
		wr(ADDR_EN_A, 8'h01);
		pins(2'h2);
		repeat (40) @(negedge clk_sys_i);
		chk("gie off", 8'h00, {7'h0, req_valid_o});
		wr(ADDR_EN_A, 8'h80);
		repeat (40) @(negedge clk_sys_i);
		chk("src off", 8'h00, {7'h0, req_valid_o});
		wr(ADDR_EN_A, 8'h81);
		wait_req(1'b1);
		chk("src", 8'h00, {4'h0, req_src_o});
		rd(ADDR_CTRL, 8'h04, "level flag");
		pulse(3'h4);
		repeat (2) @(negedge clk_sys_i);
		chk("in service", 8'h00, {7'h0, req_valid_o});
		rd(ADDR_ACT, 8'h04, "active");
		pulse(3'h2);
		wait_req(1'b1);
		pins(2'h3);
		wait_req(1'b0);
		rd(ADDR_CTRL, 8'h00, "flag gone");
		$display("test level done");
	endtask
	task automatic t_edge;
		wr(ADDR_STAT, 8'h03);
		rd(ADDR_STAT, 8'h00, "status clear");
		wr(ADDR_CTRL, 8'h01);
		pins(2'h2);
		wait_req(1'b1);
		rd(ADDR_CTRL, 8'h05, "edge flag");
		rd(ADDR_STAT, 8'h01, "status");
		chk("irq masked", 8'h00, {7'h0, irq_o});
		ack_src_i <= 4'h0;
		pulse(3'h4);
		wait_req(1'b0);
		rd(ADDR_CTRL, 8'h01, "flag cleared");
		pulse(3'h2);
		wr(ADDR_MASK, 8'h01);
		repeat (2) @(negedge clk_sys_i);
		chk("irq on", 8'h01, {7'h0, irq_o});
		wr(ADDR_STAT, 8'h01);
		repeat (2) @(negedge clk_sys_i);
		chk("irq off", 8'h00, {7'h0, irq_o});
		pins(2'h3);
		wr(ADDR_CTRL, 8'h00);
		repeat (20) @(negedge clk_sys_i);
		wr(ADDR_EN_A, 8'h84);
		wr(ADDR_CTRL, 8'h02);
		pins(2'h1);
		wait_req(1'b1);
		chk("pin1 src", 8'h02, {4'h0, req_src_o});
		ack_src_i <= 4'h2;
		pulse(3'h4);
		rd(ADDR_CTRL, 8'h02, "pin1 cleared");
		pulse(3'h2);
		repeat (3) @(negedge clk_sys_i);
		chk("no re-request", 8'h00, {7'h0, req_valid_o});
		pins(2'h3);
		wr(ADDR_CTRL, 8'h00);
		repeat (20) @(negedge clk_sys_i);
		$display("test edge done");
	endtask
	task automatic t_prio;
		wr(ADDR_EN_A, 8'h85);
		wr(ADDR_PRIO_LO, 8'h04);
		pins(2'h0);
		wait_req(1'b1);
		repeat (20) @(negedge clk_sys_i);
		chk("win src", 8'h02, {4'h0, req_src_o});
		chk("win lvl", 8'h01, {6'h0, req_level_o});
		wr(ADDR_PRIO_HI, 8'h04);
		repeat (3) @(negedge clk_sys_i);
		chk("lvl 3", 8'h03, {6'h0, req_level_o});
		wr(ADDR_PRIO_LO, 8'h00);
		wr(ADDR_PRIO_HI, 8'h00);
		repeat (3) @(negedge clk_sys_i);
		chk("tie src", 8'h00, {4'h0, req_src_o});
		pins(2'h3);
		wait_req(1'b0);
		$display("test prio done");
	endtask
	task automatic t_src;
		wr(ADDR_EN_A, 8'h80);
		wr(ADDR_EN_B, 8'h20);
		int_src_i <= 11'h400;
		wait_req(1'b1);
		chk("src 12", 8'h0C, {4'h0, req_src_o});
		wr(ADDR_EN_A, 8'h82);
		int_src_i <= 11'h401;
		repeat (3) @(negedge clk_sys_i);
		chk("tie low", 8'h01, {4'h0, req_src_o});
		int_src_i <= 11'h000;
		wr(ADDR_EN_B, 8'h00);
		wait_req(1'b0);
		$display("test src done");
	endtask
	task automatic t_wake;
		int k;
		wr(ADDR_EN_A, 8'h84);
		pulse(3'h1);
		pins(2'h1);
		for (k = 0; k < 80 && wake_o !== 1'b1; k++) @(negedge clk_sys_i);
		chk("wake", 8'h01, {7'h0, wake_o});
		if (k == 80) close_out();
		pins(2'h3);
		wait_req(1'b0);
		$display("test wake done");
	endtask
	initial begin
		{nrst_i, ack_i, ret_i, sleep_i, wr_i, rd_i} = 6'h0;
		want_n = 2'h3;
		int_src_i = 11'h000;
		ack_src_i = 4'h0;
		addr_i = 4'h0;
		wdata_i = 8'h00;
		repeat (8) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		t_regs();
		t_level();
		t_edge();
		t_prio();
		t_src();
		t_wake();
		close_out();
	end
endmodule
`default_nettype wire
